// file: hdl/smpc_delay_timer.sv
// Purpose: down-counter that times the wake-up start-up and halt phases
// Assumes: a load of zero is never issued; caller skips zero-length phases
// Notes: done_o is high during the last counted cycle, so a load of N spans N cycles
`default_nettype none
module smpc_delay_timer
    import smpc_pkg::*;
#(
    parameter int W = DLY_W
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic load_i,
    input wire logic [W-1:0] count_i,
    output logic busy_o,
    output logic done_o
);
    logic [W-1:0] cnt_r;

    initial begin
        if (W < 4 || W > 16) begin
            $error("smpc_delay_timer: W out of range");
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else if (ce_i) begin
            if (load_i) begin
                cnt_r <= count_i;
            end else if (cnt_r != '0) begin
                cnt_r <= cnt_r - W'(1);
            end
        end
    end

    // decoded from the count, not registered: a registered strobe adds a cycle per phase
    assign busy_o = (cnt_r != '0);
    assign done_o = (cnt_r == W'(1));
endmodule : smpc_delay_timer
`default_nettype wire

// file: hdl/smpc_pkg.sv
// Purpose: shared constants and types of the sleep-mode power controller
// Assumes: 10 MHz system clock
// Notes: all mode codes, fixed timing counts and carrier structs live here; the start-up count is a parameter of smpc_top
`default_nettype none
package smpc_pkg;
    // sleep mode codes on sleep_mode_select
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_NOISE_RED = 3'h1;
    localparam logic [2:0] MODE_POWER_DOWN = 3'h2;
    localparam logic [2:0] MODE_POWER_SAVE = 3'h3;
    localparam logic [2:0] MODE_UNUSED_A = 3'h4;
    localparam logic [2:0] MODE_UNUSED_B = 3'h5;
    localparam logic [2:0] MODE_STANDBY = 3'h6;
    localparam logic [2:0] MODE_EXT_STANDBY = 3'h7;

    // timing
    localparam int CLK_KHZ = 10000;
    localparam int BOD_WAKE_US = 60;
    localparam int BOD_WAKE_CYC = (BOD_WAKE_US * CLK_KHZ + 999) / 1000;
    localparam int HALT_CYC = 4;
    localparam int STBY_WAKE_CYC = 6;
    localparam int STBY_START_CYC = STBY_WAKE_CYC - HALT_CYC;
    localparam int BROWNOUT_SLEEP_OFF_WIN_CYC = 4;
    localparam int DLY_W = 12;
    localparam logic [DLY_W-1:0] DLY_ZERO = 12'h000;
    localparam logic [DLY_W-1:0] DLY_ONE = 12'h001;
    localparam logic [DLY_W-1:0] DLY_HALT = DLY_W'(HALT_CYC);
    localparam logic [DLY_W-1:0] DLY_STBY = DLY_W'(STBY_START_CYC);
    localparam logic [DLY_W-1:0] DLY_BOD = DLY_W'(BOD_WAKE_CYC - HALT_CYC);
    localparam logic [2:0] BROWNOUT_SLEEP_OFF_WIN = 3'(BROWNOUT_SLEEP_OFF_WIN_CYC);
    localparam logic BROWNOUT_SLEEP_OFF_RESET = 1'b0;

    // interrupt requests that may wake the core
    typedef struct packed {
        logic [1:0] ext_level;
        logic [1:0] ext_edge;
        logic pin_change;
        logic twi_match;
        logic timer2;
        logic spm_ee_ready;
        logic adc_done;
        logic wdt;
        logic other_io;
    } smpc_wake_t;

    // clock domain and oscillator enables
    typedef struct packed {
        logic core_clock;
        logic program_memory_clock;
        logic peripheral_clock;
        logic converter_clock;
        logic async_clock;
        logic main_osc;
        logic timer_osc;
    } smpc_clk_en_t;

    localparam smpc_clk_en_t CLK_ALL_ON = 7'h7f;
endpackage : smpc_pkg
`default_nettype wire

// file: hdl/smpc_top.sv
// Purpose: sleep entry, clock gating, wake-up sequencing, supply monitor control
// Assumes: sleep instruction, interrupts and reset requests come from same-clock logic
// Notes: the controller itself stays clocked in every mode; clocks it stops are enables
`default_nettype none
module smpc_top
    import smpc_pkg::*;
#(
    parameter int STARTUP_CYCLES = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic sleep_arm_bit_i,
    input wire logic [2:0] sleep_mode_select_i,
    input wire logic sleep_instr_i,
    input wire logic adc_enabled_i,
    input wire logic timer2_async_i,
    input wire logic monitor_fuse_en_i,
    input wire logic brownout_sleep_off_unlock_i,
    input wire logic brownout_sleep_off_wr_i,
    input wire logic brownout_sleep_off_wdata_i,
    input wire smpc_wake_t wake_req_i,
    input wire logic reset_req_i,
    output smpc_clk_en_t clk_en_o,
    output logic brownout_sleep_off_o,
    output logic supply_drop_monitor_en_o,
    output logic adc_start_o,
    output logic cpu_halt_o,
    output logic sleeping_o,
    output logic irq_service_o,
    output logic reset_vector_o,
    output logic sleep_nop_o
);
    typedef enum logic [2:0] {
        ST_ACTIVE,
        ST_SLEEP,
        ST_START,
        ST_HALT
    } smpc_state_t;

    localparam logic [DLY_W-1:0] DLY_STARTUP = DLY_W'(STARTUP_CYCLES);

    initial begin
        if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 4095) begin
            $error("smpc_top: STARTUP_CYCLES must lie in 1..4095");
        end
    end

    smpc_state_t state_r;
    smpc_state_t state_nxt;
    logic [2:0] mode_r;
    logic bod_off_r;
    logic brownout_sleep_off_r;
    logic [2:0] brownout_sleep_off_win_r;
    smpc_clk_en_t clk_en_r;
    smpc_clk_en_t clk_en_nxt;
    logic adc_start_r;
    logic irq_service_r;
    logic reset_vector_r;
    logic sleep_nop_r;
    logic monitor_en_r;

    logic mode_valid;
    logic mode_deep_sel;
    logic enter_sleep;
    logic irq_wake;
    logic tmr_load;
    logic [DLY_W-1:0] tmr_count;
    logic tmr_done;
    logic [DLY_W-1:0] start_count;
    logic [2:0] mode_nxt;

    smpc_wake_filter u_wake_filter (
        .mode_i(mode_r),
        .timer2_async_i(timer2_async_i),
        .req_i(wake_req_i),
        .wake_o(irq_wake)
    );

    smpc_delay_timer #(
        .W(DLY_W)
    ) u_delay_timer (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .load_i(tmr_load),
        .count_i(tmr_count),
        .busy_o(),
        .done_o(tmr_done)
    );

    // unassigned codes never sleep
    assign mode_valid = (sleep_mode_select_i != MODE_UNUSED_A)
        && (sleep_mode_select_i != MODE_UNUSED_B);
    // modes in which software may silence the monitor
    assign mode_deep_sel = (sleep_mode_select_i == MODE_POWER_DOWN)
        || (sleep_mode_select_i == MODE_POWER_SAVE)
        || (sleep_mode_select_i == MODE_STANDBY)
        || (sleep_mode_select_i == MODE_EXT_STANDBY);
    assign enter_sleep = (state_r == ST_ACTIVE) && sleep_instr_i
        && sleep_arm_bit_i && mode_valid && !reset_req_i;

    // start-up length depends on which oscillator stopped
    always_comb begin
        start_count = DLY_ZERO;
        case (mode_r)
            MODE_STANDBY, MODE_EXT_STANDBY: begin
                start_count = DLY_STBY;
            end
            MODE_POWER_DOWN, MODE_POWER_SAVE: begin
                start_count = DLY_STARTUP;
            end
            default: begin
                start_count = DLY_ZERO;
            end
        endcase
        // monitor needs time to settle before code may run
        if (bod_off_r && start_count < DLY_BOD) begin
            start_count = DLY_BOD;
        end
    end

    always_comb begin
        state_nxt = state_r;
        tmr_load = 1'b0;
        tmr_count = DLY_HALT;
        case (state_r)
            ST_ACTIVE: begin
                if (enter_sleep) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (irq_wake) begin
                    tmr_load = 1'b1;
                    if (start_count == DLY_ZERO) begin
                        state_nxt = ST_HALT;
                        tmr_count = DLY_HALT;
                    end else begin
                        state_nxt = ST_START;
                        tmr_count = start_count;
                    end
                end
            end
            ST_START: begin
                if (tmr_done) begin
                    state_nxt = ST_HALT;
                    tmr_load = 1'b1;
                    tmr_count = DLY_HALT;
                end
            end
            ST_HALT: begin
                if (tmr_done) begin
                    state_nxt = ST_ACTIVE;
                end
            end
            default: begin
                state_nxt = ST_ACTIVE;
            end
        endcase
        // a reset overrides every phase of sleep and wake
        if (reset_req_i) begin
            state_nxt = ST_ACTIVE;
            tmr_load = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_r <= ST_ACTIVE;
        end else if (ce_i) begin
            state_r <= state_nxt;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mode_r <= MODE_IDLE;
        end else if (ce_i && enter_sleep) begin
            mode_r <= sleep_mode_select_i;
        end
    end
    // timed unlock: a write counts only inside the window after the unlock strobe
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            brownout_sleep_off_win_r <= 3'h0;
        end else if (ce_i) begin
            if (brownout_sleep_off_unlock_i && brownout_sleep_off_win_r == 3'h0) begin
                brownout_sleep_off_win_r <= BROWNOUT_SLEEP_OFF_WIN;
            end else if (brownout_sleep_off_wr_i) begin
                brownout_sleep_off_win_r <= 3'h0;
            end else if (brownout_sleep_off_win_r != 3'h0) begin
                brownout_sleep_off_win_r <= brownout_sleep_off_win_r - 3'h1;
            end
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            brownout_sleep_off_r <= BROWNOUT_SLEEP_OFF_RESET;
        end else if (ce_i && brownout_sleep_off_wr_i && brownout_sleep_off_win_r != 3'h0) begin
            brownout_sleep_off_r <= brownout_sleep_off_wdata_i;
        end
    end
    // monitor off only for deep modes, restored at the first wake or reset edge
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            bod_off_r <= 1'b0;
        end else if (ce_i) begin
            if (enter_sleep) begin
                bod_off_r <= brownout_sleep_off_r && mode_deep_sel;
            end else if (state_r == ST_ACTIVE) begin
                bod_off_r <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            monitor_en_r <= 1'b0;
        end else if (ce_i) begin
            if (enter_sleep) begin
                monitor_en_r <= monitor_fuse_en_i && !(brownout_sleep_off_r && mode_deep_sel);
            end else if (state_r != ST_SLEEP || irq_wake || reset_req_i) begin
                monitor_en_r <= monitor_fuse_en_i;
            end
        end
    end
    // mode that the sleep state will use in the next cycle
    assign mode_nxt = enter_sleep ? sleep_mode_select_i : mode_r;

    // clock enables follow the phase; registered so gating is glitch free
    always_comb begin
        clk_en_nxt = CLK_ALL_ON;
        clk_en_nxt.timer_osc = timer2_async_i;
        if (state_nxt == ST_SLEEP) begin
            clk_en_nxt.core_clock = 1'b0;
            clk_en_nxt.program_memory_clock = 1'b0;
            clk_en_nxt.peripheral_clock = (mode_nxt == MODE_IDLE);
            clk_en_nxt.converter_clock = (mode_nxt == MODE_IDLE)
                || (mode_nxt == MODE_NOISE_RED);
            case (mode_nxt)
                MODE_IDLE: begin
                    clk_en_nxt.async_clock = 1'b1;
                    clk_en_nxt.main_osc = 1'b1;
                end
                MODE_NOISE_RED, MODE_POWER_SAVE: begin
                    clk_en_nxt.async_clock = timer2_async_i;
                    clk_en_nxt.main_osc = (mode_nxt == MODE_NOISE_RED);
                end
                MODE_EXT_STANDBY: begin
                    clk_en_nxt.async_clock = timer2_async_i;
                    clk_en_nxt.main_osc = 1'b1;
                end
                MODE_STANDBY: begin
                    clk_en_nxt.async_clock = 1'b0;
                    clk_en_nxt.main_osc = 1'b1;
                    clk_en_nxt.timer_osc = 1'b0;
                end
                default: begin
                    clk_en_nxt.async_clock = 1'b0;
                    clk_en_nxt.main_osc = 1'b0;
                    clk_en_nxt.timer_osc = 1'b0;
                end
            endcase
        end else if (state_nxt == ST_START || state_nxt == ST_HALT) begin
            // the core stays halted; only the core clock waits for resume
            clk_en_nxt.core_clock = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            clk_en_r <= CLK_ALL_ON;
        end else if (ce_i) begin
            clk_en_r <= clk_en_nxt;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            adc_start_r <= 1'b0;
        end else if (ce_i) begin
            adc_start_r <= enter_sleep && adc_enabled_i
                && (sleep_mode_select_i == MODE_NOISE_RED);
        end
    end
    // an interrupt wake resumes after the sleep instruction; no state is cleared
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            irq_service_r <= 1'b0;
        end else if (ce_i) begin
            irq_service_r <= (state_r == ST_HALT) && tmr_done && !reset_req_i;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            reset_vector_r <= 1'b0;
        end else if (ce_i) begin
            reset_vector_r <= reset_req_i && (state_r != ST_ACTIVE);
        end
    end
    // sleep attempted without arm or with an unassigned code
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sleep_nop_r <= 1'b0;
        end else if (ce_i) begin
            sleep_nop_r <= (state_r == ST_ACTIVE) && sleep_instr_i
                && !(sleep_arm_bit_i && mode_valid);
        end
    end

    assign clk_en_o = clk_en_r;
    assign brownout_sleep_off_o = brownout_sleep_off_r;
    assign supply_drop_monitor_en_o = monitor_en_r;
    assign adc_start_o = adc_start_r;
    assign cpu_halt_o = (state_r != ST_ACTIVE);
    assign sleeping_o = (state_r == ST_SLEEP);
    assign irq_service_o = irq_service_r;
    assign reset_vector_o = reset_vector_r;
    assign sleep_nop_o = sleep_nop_r;
endmodule : smpc_top
`default_nettype wire

// file: hdl/smpc_wake_filter.sv
// Purpose: selects which interrupt requests may wake the core in each mode
// Assumes: requests are levels from logic on the system clock
// Notes: purely combinational
`default_nettype none
module smpc_wake_filter
    import smpc_pkg::*;
(
    input wire logic [2:0] mode_i,
    input wire logic timer2_async_i,
    input wire smpc_wake_t req_i,
    output logic wake_o
);
    logic common;

    // level interrupts, pin change, address match and watchdog wake every mode
    assign common = |req_i.ext_level | req_i.pin_change | req_i.twi_match | req_i.wdt;

    always_comb begin
        wake_o = 1'b0;
        case (mode_i)
            MODE_IDLE: begin
                wake_o = |req_i;
            end
            MODE_NOISE_RED: begin
                wake_o = common | req_i.adc_done | req_i.spm_ee_ready
                    | (req_i.timer2 & timer2_async_i);
            end
            MODE_POWER_DOWN, MODE_STANDBY: begin
                wake_o = common;
            end
            MODE_POWER_SAVE, MODE_EXT_STANDBY: begin
                wake_o = common | req_i.timer2;
            end
            default: begin
                wake_o = 1'b0;
            end
        endcase
    end
endmodule : smpc_wake_filter
`default_nettype wire

// file: testbench/smpc_cpu_model.sv
// Purpose: software side of the core: arms and executes sleep, writes the monitor bit
// Assumes: drives only at falling edges of the system clock
// Notes: the arm bit is set a cycle before the instruction, as software must
`default_nettype none
module smpc_cpu_model (
    input wire logic clk_sys_i,
    output logic sleep_arm_bit_o,
    output logic [2:0] sleep_mode_select_o,
    output logic sleep_instr_o,
    output logic brownout_sleep_off_unlock_o,
    output logic brownout_sleep_off_wr_o,
    output logic brownout_sleep_off_wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sleep_arm_bit_o = 1'b0;
        sleep_mode_select_o = 3'h0;
        sleep_instr_o = 1'b0;
        brownout_sleep_off_unlock_o = 1'b0;
        brownout_sleep_off_wr_o = 1'b0;
        brownout_sleep_off_wdata_o = 1'b0;
    end

    task automatic do_sleep(input logic arm, input logic [2:0] mode);
        @(negedge clk_sys_i);
        sleep_arm_bit_o <= arm;
        sleep_mode_select_o <= mode;
        @(negedge clk_sys_i);
        sleep_instr_o <= 1'b1;
        @(negedge clk_sys_i);
        sleep_instr_o <= 1'b0;
    endtask : do_sleep

    // unlock=0 skips the guard pulse, so the write must be refused
    task automatic brownout_sleep_off_write(input logic unlock, input logic val);
        @(negedge clk_sys_i);
        brownout_sleep_off_unlock_o <= unlock;
        @(negedge clk_sys_i);
        brownout_sleep_off_unlock_o <= 1'b0;
        brownout_sleep_off_wr_o <= 1'b1;
        brownout_sleep_off_wdata_o <= val;
        @(negedge clk_sys_i);
        brownout_sleep_off_wr_o <= 1'b0;
    endtask : brownout_sleep_off_write
endmodule : smpc_cpu_model
`default_nettype wire

// file: testbench/smpc_top_assertions.sv
// Purpose: port-level checks of sleep entry, gating, wake-up and monitor control
// Assumes: sees only smpc_top ports; one clock domain
// Notes: entry is judged from inputs, so a wrong state decode shows up here
`default_nettype none
module smpc_top_assertions
    import smpc_pkg::*;
#(
    parameter int STARTUP_CYCLES = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic sleep_arm_bit_i,
    input wire logic [2:0] sleep_mode_select_i,
    input wire logic sleep_instr_i,
    input wire logic adc_enabled_i,
    input wire logic timer2_async_i,
    input wire logic monitor_fuse_en_i,
    input wire logic brownout_sleep_off_unlock_i,
    input wire logic brownout_sleep_off_wr_i,
    input wire logic brownout_sleep_off_wdata_i,
    input wire smpc_wake_t wake_req_i,
    input wire logic reset_req_i,
    input wire smpc_clk_en_t clk_en_o,
    input wire logic brownout_sleep_off_o,
    input wire logic supply_drop_monitor_en_o,
    input wire logic adc_start_o,
    input wire logic cpu_halt_o,
    input wire logic sleeping_o,
    input wire logic irq_service_o,
    input wire logic reset_vector_o,
    input wire logic sleep_nop_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic go;
    logic quiet;
    // a request that must be taken: core running, armed, code assigned, no reset
    assign go = ce_i && sleep_instr_i && sleep_arm_bit_i && !cpu_halt_o && !reset_req_i
        && (sleep_mode_select_i[2:1] != 2'b10);
    // only edge-triggered external requests pending
    assign quiet = (wake_req_i[10:9] == 2'h0) && (wake_req_i[6:0] == 7'h00) && !reset_req_i;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    property p_entry;
        go |=> sleeping_o && cpu_halt_o;
    endproperty
    a_entry: assert property (p_entry) else $error("sleep entry missed");
    property p_nop;
        ce_i && sleep_instr_i && !cpu_halt_o && !reset_req_i
            && (!sleep_arm_bit_i || sleep_mode_select_i[2:1] == 2'b10)
            |=> sleep_nop_o && !sleeping_o;
    endproperty
    a_nop: assert property (p_nop) else $error("ignored sleep not flagged");
    property p_idle_clk;
        go && sleep_mode_select_i == MODE_IDLE |=> !clk_en_o.core_clock
            && !clk_en_o.program_memory_clock && clk_en_o.peripheral_clock
            && clk_en_o.converter_clock;
    endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("idle gating wrong");
    property p_noise;
        go && sleep_mode_select_i == MODE_NOISE_RED |=> !clk_en_o.peripheral_clock
            && clk_en_o.converter_clock && (adc_start_o == $past(adc_enabled_i));
    endproperty
    a_noise: assert property (p_noise) else $error("noise mode entry wrong");
    property p_osc;
        go && sleep_mode_select_i[1] |=> clk_en_o.main_osc == $past(sleep_mode_select_i[2]);
    endproperty
    a_osc: assert property (p_osc) else $error("main oscillator wrong");
    property p_bod_keep;
        go && !sleep_mode_select_i[1] && monitor_fuse_en_i |=> supply_drop_monitor_en_o;
    endproperty
    a_bod_keep: assert property (p_bod_keep) else $error("monitor off in light mode");
    property p_bod_off;
        go && sleep_mode_select_i[1] && brownout_sleep_off_o |=> !supply_drop_monitor_en_o;
    endproperty
    a_bod_off: assert property (p_bod_off) else $error("monitor kept on");
    property p_halt;
        irq_service_o |-> !cpu_halt_o && $past(cpu_halt_o) && $past(cpu_halt_o, 4);
    endproperty
    a_halt: assert property (p_halt) else $error("halt phase too short");
    property p_reset;
        ce_i && reset_req_i && cpu_halt_o |=> reset_vector_o && !cpu_halt_o
            && clk_en_o.core_clock;
    endproperty
    a_reset: assert property (p_reset) else $error("reset did not wake");
    property p_idle_wake;
        ce_i && sleeping_o && clk_en_o.peripheral_clock && (wake_req_i != 11'h000)
            && !reset_req_i |=> !sleeping_o;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle did not wake");
    property p_edge_block;
        ce_i && sleeping_o && !clk_en_o.peripheral_clock && quiet |=> sleeping_o;
    endproperty
    a_edge_block: assert property (p_edge_block) else $error("edge woke deep mode");

    c_service: cover property (irq_service_o);
    c_reset: cover property (reset_vector_o);
    c_convert: cover property (adc_start_o);
endmodule : smpc_top_assertions

bind smpc_top smpc_top_assertions #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
    .sleep_arm_bit_i(sleep_arm_bit_i), .sleep_mode_select_i(sleep_mode_select_i),
    .sleep_instr_i(sleep_instr_i), .adc_enabled_i(adc_enabled_i),
    .timer2_async_i(timer2_async_i), .monitor_fuse_en_i(monitor_fuse_en_i),
    .brownout_sleep_off_unlock_i(brownout_sleep_off_unlock_i), .brownout_sleep_off_wr_i(brownout_sleep_off_wr_i), .brownout_sleep_off_wdata_i(brownout_sleep_off_wdata_i),
    .wake_req_i(wake_req_i), .reset_req_i(reset_req_i), .clk_en_o(clk_en_o),
    .brownout_sleep_off_o(brownout_sleep_off_o),
    .supply_drop_monitor_en_o(supply_drop_monitor_en_o), .adc_start_o(adc_start_o),
    .cpu_halt_o(cpu_halt_o), .sleeping_o(sleeping_o), .irq_service_o(irq_service_o),
    .reset_vector_o(reset_vector_o), .sleep_nop_o(sleep_nop_o)
);
`default_nettype wire

// file: testbench/smpc_top_bench.sv
// Purpose: self-checking run over every sleep mode, wake filter, reset and monitor control
// Assumes: short start-up parameter; converter enabled and monitor fuse on throughout
// Notes: wake latency is counted in falling edges from the request being applied
`default_nettype none
module smpc_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import smpc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic arm, instr, unlock, wr, wdata, brownout_sleep_off_off, mon_en, adc_start, halt, sleeping;
    logic irq_svc, rst_vec, nop;
    logic [2:0] mode;
    logic t2_async = 1'b1;
    logic reset_req = 1'b0;
    logic ce = 1'b1;
    smpc_wake_t wake = '0;
    smpc_clk_en_t clk_en;
    int fails = 0;
    int tests_run = 0;
    int n;
    logic [2:0] md [6] = '{MODE_IDLE, MODE_NOISE_RED, MODE_POWER_DOWN, MODE_POWER_SAVE,
        MODE_STANDBY, MODE_EXT_STANDBY};
    logic [6:0] ck [6] = '{7'h1f, 7'h0f, 7'h00, 7'h05, 7'h02, 7'h07};
    // per mode: a source that must not wake (none in idle), then one that must
    logic [10:0] bad [6] = '{11'h000, 11'h001, 11'h080, 11'h001, 11'h010, 11'h080};
    logic [10:0] good [6] = '{11'h001, 11'h004, 11'h200, 11'h010, 11'h040, 11'h020};

    always #50 clk_sys_i = ~clk_sys_i;

    smpc_cpu_model cpu (.clk_sys_i(clk_sys_i), .sleep_arm_bit_o(arm),
        .sleep_mode_select_o(mode), .sleep_instr_o(instr), .brownout_sleep_off_unlock_o(unlock),
        .brownout_sleep_off_wr_o(wr), .brownout_sleep_off_wdata_o(wdata));

    smpc_top #(.STARTUP_CYCLES(2)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
        .sleep_arm_bit_i(arm), .sleep_mode_select_i(mode), .sleep_instr_i(instr),
        .adc_enabled_i(1'b1), .timer2_async_i(t2_async), .monitor_fuse_en_i(1'b1),
        .brownout_sleep_off_unlock_i(unlock), .brownout_sleep_off_wr_i(wr), .brownout_sleep_off_wdata_i(wdata), .wake_req_i(wake),
        .reset_req_i(reset_req), .clk_en_o(clk_en), .brownout_sleep_off_o(brownout_sleep_off_off),
        .supply_drop_monitor_en_o(mon_en), .adc_start_o(adc_start), .cpu_halt_o(halt),
        .sleeping_o(sleeping), .irq_service_o(irq_svc), .reset_vector_o(rst_vec),
        .sleep_nop_o(nop));

    task automatic check(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask : check

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic wait_svc(input int lim, output int cnt);
        cnt = 0;
        while (irq_svc !== 1'b1) begin
            @(negedge clk_sys_i);
            cnt++;
            if (cnt > lim) begin
                check(1'b0, "wake never completed");
                close_out();
            end
        end
    endtask : wait_svc

    initial begin
        repeat (3) @(negedge clk_sys_i);
        rst_i <= 1'b0;
        @(negedge clk_sys_i);
        check(clk_en === CLK_ALL_ON && halt === 1'b0 && mon_en === 1'b1, "after reset");
        check(brownout_sleep_off_off === 1'b0, "sleep-off bit reset value");
        ce <= 1'b0;
        cpu.do_sleep(1'b1, MODE_IDLE);
        check(sleeping === 1'b0 && nop === 1'b0, "frozen block took sleep");
        ce <= 1'b1;
        cpu.do_sleep(1'b0, MODE_POWER_DOWN);
        check(nop === 1'b1 && sleeping === 1'b0, "unarmed sleep taken");
        for (int m = 4; m < 6; m++) begin
            cpu.do_sleep(1'b1, 3'(m));
            check(nop === 1'b1 && halt === 1'b0, "unused code slept");
        end
        for (int i = 0; i < 6; i++) begin
            cpu.do_sleep(1'b1, md[i]);
            check(sleeping === 1'b1 && halt === 1'b1, "no entry");
            check(clk_en === ck[i], "clock gating");
            check(adc_start === (md[i] == MODE_NOISE_RED), "conversion start");
            wake <= bad[i];
            repeat (3) @(negedge clk_sys_i);
            check(sleeping === 1'b1, "woken by blocked source");
            wake <= good[i];
            wait_svc(40, n);
            wake <= '0;
            check(n >= HALT_CYC + 1, "halt too short");
            if (md[i][2]) begin
                check(n <= STBY_WAKE_CYC + 1, "standby wake slow");
            end
            check(halt === 1'b0 && clk_en === CLK_ALL_ON, "not resumed");
        end
        t2_async <= 1'b0;
        cpu.do_sleep(1'b1, MODE_POWER_SAVE);
        check(clk_en === 7'h00, "timer domain kept without async");
        reset_req <= 1'b1;
        @(negedge clk_sys_i);
        reset_req <= 1'b0;
        check(rst_vec === 1'b1 && halt === 1'b0 && irq_svc === 1'b0, "reset wake");
        t2_async <= 1'b1;
        cpu.brownout_sleep_off_write(1'b1, 1'b1);
        @(negedge clk_sys_i);
        check(brownout_sleep_off_off === 1'b1, "unlocked write lost");
        cpu.brownout_sleep_off_write(1'b0, 1'b0);
        @(negedge clk_sys_i);
        check(brownout_sleep_off_off === 1'b1, "locked write taken");
        cpu.do_sleep(1'b1, MODE_NOISE_RED);
        check(mon_en === 1'b1, "monitor off in noise mode");
        wake <= 11'h004;
        wait_svc(40, n);
        wake <= '0;
        check(n < 20, "light mode wake stretched");
        cpu.do_sleep(1'b1, MODE_POWER_DOWN);
        check(mon_en === 1'b0, "monitor kept on");
        wake <= 11'h200;
        @(negedge clk_sys_i);
        check(mon_en === 1'b1, "monitor not back");
        wait_svc(700, n);
        wake <= '0;
        check(n + 1 >= BOD_WAKE_CYC - 2 && n + 1 <= BOD_WAKE_CYC + 6, "stretch");
        close_out();
    end
endmodule : smpc_top_bench
`default_nettype wire
